// ### core/msgu_pkg.sv
// Functional notes
// - With the enable strap low, registers are hidden from PCI (CPU access still works) and the window decodes as SDRAM.
// - No index or window-select registers; their locations go to SDRAM.
// - PCI write to an inbound message register sets a cause bit; unmasked, interrupts CPU.
// - Inbound message cause clears only on CPU write of one; mask gates CPU interrupt.
// - CPU write to an outbound message register sets a cause bit; unmasked, interrupts PCI.
// - Outbound message cause clears only on PCI write of one; mask gates PCI interrupt.
// - PCI sets inbound doorbell bits, requesting a CPU interrupt; masking never blocks setting.
// - CPU sets outbound doorbell bits, requesting a PCI interrupt; masking never blocks setting.
// - Four circular queues of 32-bit entries live in SDRAM at the queue base.
// - All queues share one size, 4K to 64K entries, in one contiguous region.
// - Queue starts: free in at base, post in +1, post out +2, free out +3 sizes.
// - Head and tail pointers are offsets; writes go to head, reads from tail.
// - A pointer reaching the queue size wraps to the first entry.
// - Queue accesses are single word; a burst is disconnected after one data phase.
// - Queue ports have no storage; each accepted write and non-empty read goes to the pointed SDRAM entry.
// - PCI write to the inbound port posts an entry and interrupts the CPU.
// - PCI read of the inbound port returns the inbound free queue tail entry.
// - PCI read of the outbound port returns the outbound post queue tail entry.
// - PCI write to the outbound port stores a returned entry on the outbound free queue.
// - After a port write reaches SDRAM, the head advances by one word.
// - Reading an empty queue returns all ones; otherwise the tail advances.
// - Port write is retried while a port write is pending or queue is full.
// - Outbound post head differing from tail requests a PCI interrupt, maskable.
package msgu_pkg;

  // ****************************************
  // Register offsets within the window
  // ****************************************
  localparam logic [7:0] OFF_IN_MSG0 = 8'h10;
  localparam logic [7:0] OFF_IN_MSG1 = 8'h14;
  localparam logic [7:0] OFF_OUT_MSG0 = 8'h18;
  localparam logic [7:0] OFF_OUT_MSG1 = 8'h1C;
  localparam logic [7:0] OFF_IN_DB = 8'h20;
  localparam logic [7:0] OFF_IN_CAUSE = 8'h24;
  localparam logic [7:0] OFF_IN_MASK = 8'h28;
  localparam logic [7:0] OFF_OUT_DB = 8'h2C;
  localparam logic [7:0] OFF_OUT_CAUSE = 8'h30;
  localparam logic [7:0] OFF_OUT_MASK = 8'h34;
  localparam logic [7:0] OFF_IN_PORT = 8'h40;
  localparam logic [7:0] OFF_OUT_PORT = 8'h44;
  localparam logic [7:0] OFF_QCTRL = 8'h50;
  localparam logic [7:0] OFF_QBASE = 8'h54;
  localparam logic [7:0] OFF_PTR_BASE = 8'h60;
  localparam logic [7:0] OFF_INDEX_END = 8'h10;
  localparam logic [7:0] OFF_WIN_END = 8'h7F;
  localparam logic [31:0] CPU_BASE = 32'h00001C00;

  // ****************************************
  // Fields, reset values and sizes
  // ****************************************
  localparam int CB_MSG0 = 0;
  localparam int CB_MSG1 = 1;
  localparam int CB_DB = 2;
  localparam int CB_POST = 3;
  localparam int CB_FULL = 4;
  localparam logic [4:0] IN_MASK_RST = 5'h00;
  localparam logic [3:0] OUT_MASK_RST = 4'h0;
  localparam logic [2:0] QSIZE_RST = 3'h0;
  localparam logic [2:0] QSIZE_MAX = 3'h4;
  localparam logic [18:0] QBYTES_MIN = 19'h04000;
  localparam logic [18:0] ENTRY_BYTES = 19'h00004;
  localparam logic [31:0] EMPTY_WORD = 32'hFFFFFFFF;
  localparam logic [1:0] SYNC_FILL = 2'h3;

  // Pointer indices follow the register order.
  localparam logic [1:0] Q_IN_FREE = 2'h0;
  localparam logic [1:0] Q_IN_POST = 2'h1;
  localparam logic [1:0] Q_OUT_FREE = 2'h2;
  localparam logic [1:0] Q_OUT_POST = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_QWR = 3'b001,
    ST_QRD = 3'b010,
    ST_PASS = 3'b011,
    ST_DONE = 3'b100
  } msgu_state_t;

endpackage

// ### core/msgu_top.sv
`timescale 1ns/10ps
module msgu_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Enable strap pin
  input wire logic msg_enable_strap,
  // PCI side register window
  input wire logic pci_psel,
  input wire logic pci_penable,
  input wire logic pci_pwrite,
  input wire logic [31:0] pci_paddr,
  input wire logic [31:0] pci_pwdata,
  output logic pci_pready,
  output logic pci_pslverr,
  output logic [31:0] pci_prdata,
  output logic pci_disconnect,
  // CPU side registers
  input wire logic cpu_psel,
  input wire logic cpu_penable,
  input wire logic cpu_pwrite,
  input wire logic [31:0] cpu_paddr,
  input wire logic [31:0] cpu_pwdata,
  output logic cpu_pready,
  output logic cpu_pslverr,
  output logic [31:0] cpu_prdata,
  // SDRAM access
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Interrupts
  output logic cpu_int,
  output logic pci_int
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    msgu_pkg::msgu_state_t st;
    logic out_port;
    logic [1:0][31:0] in_msg;
    logic [1:0][31:0] out_msg;
    logic [31:0] in_db;
    logic [31:0] out_db;
    logic [4:0] in_cause;
    logic [4:0] in_mask;
    logic [3:0] out_cause;
    logic [3:0] out_mask;
    logic [2:0] qsize;
    logic [11:0] qbase;
    logic [7:0][17:0] ptr;
    logic mem_req;
    logic mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [31:0] pci_rdata;
    logic [31:0] cpu_rdata;
    logic cpu_int;
    logic pci_int;
    logic [2:0] strap_sync;
    logic [1:0] sync_fill;
    logic en;
    logic en_done;
  } msgu_regs_t;

  msgu_regs_t r;
  msgu_regs_t n;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [18:0] qbytes(input logic [2:0] code);
    logic [2:0] c;
    c = (code > msgu_pkg::QSIZE_MAX) ? msgu_pkg::QSIZE_MAX : code;
    return msgu_pkg::QBYTES_MIN << c;
  endfunction

  function automatic logic [17:0] ptr_inc(input logic [17:0] p, input logic [2:0] code);
    logic [18:0] s;
    s = {1'b0, p} + msgu_pkg::ENTRY_BYTES;
    return (s >= qbytes(code)) ? 18'h00000 : s[17:0];
  endfunction

  // Byte address of entry p in queue k.
  function automatic logic [31:0] qaddr(input msgu_regs_t x, input logic [1:0] k,
                                        input logic [17:0] p);
    logic [19:0] sz;
    logic [19:0] start;
    sz = {1'b0, qbytes(x.qsize)};
    start = 20'h00000;
    case (k)
      msgu_pkg::Q_IN_POST: start = sz;
      msgu_pkg::Q_OUT_POST: start = sz << 1;
      msgu_pkg::Q_OUT_FREE: start = (sz << 1) + sz;
      default: start = 20'h00000;
    endcase
    return {x.qbase, start + {2'b00, p}};
  endfunction

  function automatic logic [4:0] in_view(input msgu_regs_t x);
    logic [4:0] v;
    v = x.in_cause;
    v[msgu_pkg::CB_DB] = |x.in_db;
    return v;
  endfunction

  function automatic logic [3:0] out_view(input msgu_regs_t x);
    logic [3:0] v;
    v = x.out_cause;
    v[msgu_pkg::CB_DB] = |x.out_db;
    v[msgu_pkg::CB_POST] = x.ptr[6] != x.ptr[7];
    return v;
  endfunction

  function automatic logic mapped(input logic [7:0] off);
    logic m;
    m = 1'b0;
    if (off[1:0] == 2'b00)
    begin
      if (off >= msgu_pkg::OFF_PTR_BASE)
        m = 1'b1;
      else if (off >= msgu_pkg::OFF_IN_MSG0 && off <= msgu_pkg::OFF_OUT_MASK)
        m = 1'b1;
      else if (off == msgu_pkg::OFF_IN_PORT || off == msgu_pkg::OFF_OUT_PORT)
        m = 1'b1;
      else if (off == msgu_pkg::OFF_QCTRL || off == msgu_pkg::OFF_QBASE)
        m = 1'b1;
    end
    return m;
  endfunction

  function automatic logic [31:0] reg_rd(input msgu_regs_t x, input logic [7:0] off);
    logic [31:0] v;
    v = 32'h00000000;
    if (off >= msgu_pkg::OFF_PTR_BASE)
      v = {14'h0000, x.ptr[off[4:2]]};
    else
    begin
      case (off)
        msgu_pkg::OFF_IN_MSG0: v = x.in_msg[0];
        msgu_pkg::OFF_IN_MSG1: v = x.in_msg[1];
        msgu_pkg::OFF_OUT_MSG0: v = x.out_msg[0];
        msgu_pkg::OFF_OUT_MSG1: v = x.out_msg[1];
        msgu_pkg::OFF_IN_DB: v = x.in_db;
        msgu_pkg::OFF_IN_CAUSE: v = {27'h0000000, in_view(x)};
        msgu_pkg::OFF_IN_MASK: v = {27'h0000000, x.in_mask};
        msgu_pkg::OFF_OUT_DB: v = x.out_db;
        msgu_pkg::OFF_OUT_CAUSE: v = {28'h0000000, out_view(x)};
        msgu_pkg::OFF_OUT_MASK: v = {28'h0000000, x.out_mask};
        msgu_pkg::OFF_QCTRL: v = {29'h00000000, x.qsize};
        msgu_pkg::OFF_QBASE: v = {x.qbase, 20'h00000};
        default: v = 32'h00000000;
      endcase
    end
    return v;
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  logic [7:0] p_off;
  logic [7:0] c_off;
  logic p_win;
  logic p_reg;
  logic p_acc;
  logic p_in_port;
  logic p_out_port;
  logic p_qport;
  logic p_need_mem;
  logic p_retry;
  logic p_wr;
  logic in_post_full;
  logic out_free_full;
  logic c_reg;
  logic c_acc;
  logic c_wr;

  assign p_off = pci_paddr[7:0];
  // Only the window above the index locations belongs to the unit while enabled.
  assign p_win = r.en && (pci_paddr[31:7] == 25'h0000000)
                 && (p_off >= msgu_pkg::OFF_INDEX_END);
  assign p_reg = p_win && mapped(p_off);
  assign p_acc = pci_psel && pci_penable;
  assign p_in_port = p_win && (p_off == msgu_pkg::OFF_IN_PORT);
  assign p_out_port = p_win && (p_off == msgu_pkg::OFF_OUT_PORT);
  assign p_qport = p_in_port || p_out_port;
  assign in_post_full = ptr_inc(r.ptr[2], r.qsize) == r.ptr[3];
  assign out_free_full = ptr_inc(r.ptr[4], r.qsize) == r.ptr[5];
  assign p_need_mem = p_acc && (!p_win || (p_qport && !pci_pwrite));
  assign p_retry = p_acc && pci_pwrite && p_qport
                   && (r.st == msgu_pkg::ST_QWR
                       || (p_in_port ? in_post_full : out_free_full));
  assign pci_pready = p_need_mem ? (r.st == msgu_pkg::ST_DONE) : 1'b1;
  assign pci_pslverr = p_retry;
  assign pci_disconnect = p_acc && pci_pready && p_qport;
  assign p_wr = p_acc && pci_pwrite && p_reg && !p_qport;

  assign c_off = cpu_paddr[7:0];
  assign c_reg = (cpu_paddr[31:7] == msgu_pkg::CPU_BASE[31:7])
                 && (c_off >= msgu_pkg::OFF_INDEX_END) && mapped(c_off)
                 && (c_off != msgu_pkg::OFF_IN_PORT) && (c_off != msgu_pkg::OFF_OUT_PORT);
  assign c_acc = cpu_psel && cpu_penable;
  assign cpu_pready = 1'b1;
  assign cpu_pslverr = c_acc && !c_reg;
  assign c_wr = c_acc && cpu_pwrite && c_reg;

  // ****************************************
  // Next state
  // ****************************************
  logic [4:0] in_set;
  logic [4:0] in_clr;
  logic [3:0] out_set;
  logic [3:0] out_clr;
  logic [31:0] in_db_set;
  logic [31:0] in_db_clr;
  logic [31:0] out_db_set;
  logic [31:0] out_db_clr;
  logic [17:0] new_head;

  always_comb
  begin
    n = r;
    in_set = 5'h00;
    in_clr = 5'h00;
    out_set = 4'h0;
    out_clr = 4'h0;
    in_db_set = 32'h00000000;
    in_db_clr = 32'h00000000;
    out_db_set = 32'h00000000;
    out_db_clr = 32'h00000000;
    new_head = 18'h00000;

    // The strap is taken once, after all stages have filled and the last two agree.
    n.strap_sync = {r.strap_sync[1:0], msg_enable_strap};
    if (r.sync_fill != msgu_pkg::SYNC_FILL)
      n.sync_fill = r.sync_fill + 2'h1;
    if (!r.en_done && (r.sync_fill == msgu_pkg::SYNC_FILL)
        && (r.strap_sync[1] == r.strap_sync[2]))
    begin
      n.en = r.strap_sync[2];
      n.en_done = 1'b1;
    end

    // Read data is latched in the setup phase.
    if (pci_psel && !pci_penable)
      n.pci_rdata = p_reg ? reg_rd(r, p_off) : 32'h00000000;
    if (cpu_psel && !cpu_penable)
      n.cpu_rdata = c_reg ? reg_rd(r, c_off) : 32'h00000000;

    if (c_wr)
    begin
      if (c_off >= msgu_pkg::OFF_PTR_BASE)
        n.ptr[c_off[4:2]] = {cpu_pwdata[17:2], 2'b00};
      else
      begin
        case (c_off)
          msgu_pkg::OFF_OUT_MSG0:
          begin
            n.out_msg[0] = cpu_pwdata;
            out_set[msgu_pkg::CB_MSG0] = 1'b1;
          end
          msgu_pkg::OFF_OUT_MSG1:
          begin
            n.out_msg[1] = cpu_pwdata;
            out_set[msgu_pkg::CB_MSG1] = 1'b1;
          end
          msgu_pkg::OFF_IN_DB: in_db_clr = cpu_pwdata;
          msgu_pkg::OFF_IN_CAUSE: in_clr = cpu_pwdata[4:0];
          msgu_pkg::OFF_IN_MASK: n.in_mask = cpu_pwdata[4:0];
          msgu_pkg::OFF_OUT_DB: out_db_set = cpu_pwdata;
          msgu_pkg::OFF_QCTRL: n.qsize = cpu_pwdata[2:0];
          msgu_pkg::OFF_QBASE: n.qbase = cpu_pwdata[31:20];
          default: n.qbase = r.qbase;
        endcase
      end
    end

    if (p_wr)
    begin
      case (p_off)
        msgu_pkg::OFF_IN_MSG0:
        begin
          n.in_msg[0] = pci_pwdata;
          in_set[msgu_pkg::CB_MSG0] = 1'b1;
        end
        msgu_pkg::OFF_IN_MSG1:
        begin
          n.in_msg[1] = pci_pwdata;
          in_set[msgu_pkg::CB_MSG1] = 1'b1;
        end
        msgu_pkg::OFF_IN_DB: in_db_set = pci_pwdata;
        msgu_pkg::OFF_OUT_DB: out_db_clr = pci_pwdata;
        msgu_pkg::OFF_OUT_CAUSE: out_clr = pci_pwdata[3:0];
        msgu_pkg::OFF_OUT_MASK: n.out_mask = pci_pwdata[3:0];
        default: n.out_mask = r.out_mask;
      endcase
    end

    // Queue port and SDRAM sequencing; hardware pointer moves win over CPU writes.
    unique case (r.st)
      msgu_pkg::ST_IDLE:
      begin
        if (p_acc && pci_pwrite && p_qport && !p_retry)
        begin
          n.st = msgu_pkg::ST_QWR;
          n.out_port = p_out_port;
          n.mem_req = 1'b1;
          n.mem_we = 1'b1;
          n.mem_wdata = pci_pwdata;
          n.mem_addr = p_out_port ? qaddr(r, msgu_pkg::Q_OUT_FREE, r.ptr[4])
                                  : qaddr(r, msgu_pkg::Q_IN_POST, r.ptr[2]);
        end
        else if (p_need_mem && !p_win)
        begin
          n.st = msgu_pkg::ST_PASS;
          n.mem_req = 1'b1;
          n.mem_we = pci_pwrite;
          n.mem_wdata = pci_pwdata;
          n.mem_addr = pci_paddr;
        end
        else if (p_need_mem)
        begin
          n.out_port = p_out_port;
          if (p_out_port ? (r.ptr[6] == r.ptr[7]) : (r.ptr[0] == r.ptr[1]))
          begin
            n.pci_rdata = msgu_pkg::EMPTY_WORD;
            n.st = msgu_pkg::ST_DONE;
          end
          else
          begin
            n.st = msgu_pkg::ST_QRD;
            n.mem_req = 1'b1;
            n.mem_we = 1'b0;
            n.mem_addr = p_out_port ? qaddr(r, msgu_pkg::Q_OUT_POST, r.ptr[7])
                                    : qaddr(r, msgu_pkg::Q_IN_FREE, r.ptr[1]);
          end
        end
      end
      msgu_pkg::ST_QWR:
      begin
        if (mem_ack)
        begin
          n.mem_req = 1'b0;
          n.st = msgu_pkg::ST_IDLE;
          if (r.out_port)
          begin
            new_head = ptr_inc(r.ptr[4], r.qsize);
            n.ptr[4] = new_head;
            if (ptr_inc(new_head, r.qsize) == r.ptr[5])
              in_set[msgu_pkg::CB_FULL] = 1'b1;
          end
          else
          begin
            n.ptr[2] = ptr_inc(r.ptr[2], r.qsize);
            in_set[msgu_pkg::CB_POST] = 1'b1;
          end
        end
      end
      msgu_pkg::ST_QRD:
      begin
        if (mem_ack)
        begin
          n.mem_req = 1'b0;
          n.pci_rdata = mem_rdata;
          n.st = msgu_pkg::ST_DONE;
          if (r.out_port)
            n.ptr[7] = ptr_inc(r.ptr[7], r.qsize);
          else
            n.ptr[1] = ptr_inc(r.ptr[1], r.qsize);
        end
      end
      msgu_pkg::ST_PASS:
      begin
        if (mem_ack)
        begin
          n.mem_req = 1'b0;
          if (!r.mem_we)
            n.pci_rdata = mem_rdata;
          n.st = msgu_pkg::ST_DONE;
        end
      end
      msgu_pkg::ST_DONE: n.st = msgu_pkg::ST_IDLE;
      default: n.st = msgu_pkg::ST_IDLE;
    endcase

    // Sticky bits: a set in the same cycle as a clear wins.
    n.in_db = (r.in_db & ~in_db_clr) | in_db_set;
    n.out_db = (r.out_db & ~out_db_clr) | out_db_set;
    n.in_cause = (r.in_cause & ~in_clr) | in_set;
    n.out_cause = (r.out_cause & ~out_clr) | out_set;
    n.in_cause[msgu_pkg::CB_DB] = 1'b0;
    n.out_cause[msgu_pkg::CB_DB] = 1'b0;
    n.out_cause[msgu_pkg::CB_POST] = 1'b0;

    n.cpu_int = |(in_view(r) & ~r.in_mask);
    n.pci_int = |(out_view(r) & ~r.out_mask);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      r <= '0;
      r.st <= msgu_pkg::ST_IDLE;
      r.in_mask <= msgu_pkg::IN_MASK_RST;
      r.out_mask <= msgu_pkg::OUT_MASK_RST;
      r.qsize <= msgu_pkg::QSIZE_RST;
    end
    else
      r <= n;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pci_prdata = r.pci_rdata;
  assign cpu_prdata = r.cpu_rdata;
  assign mem_req = r.mem_req;
  assign mem_we = r.mem_we;
  assign mem_addr = r.mem_addr;
  assign mem_wdata = r.mem_wdata;
  assign cpu_int = r.cpu_int;
  assign pci_int = r.pci_int;

endmodule

// ### tb/msgu_chk.sv
`timescale 1ns/10ps
module msgu_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // PCI side window
  input wire logic pci_psel,
  input wire logic pci_penable,
  input wire logic pci_pwrite,
  input wire logic [31:0] pci_paddr,
  input wire logic [31:0] pci_pwdata,
  input wire logic pci_pready,
  input wire logic pci_pslverr,
  input wire logic [31:0] pci_prdata,
  input wire logic pci_disconnect,
  // CPU side registers
  input wire logic cpu_psel,
  input wire logic cpu_penable,
  input wire logic cpu_pwrite,
  input wire logic [31:0] cpu_paddr,
  input wire logic [31:0] cpu_pwdata,
  input wire logic cpu_pready,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Interrupts
  input wire logic cpu_int,
  input wire logic pci_int
);
  logic port_addr;
  logic pw_port;
  logic pci_done;
  logic cpu_mask_wr;
  assign port_addr = pci_paddr == {24'h000000, msgu_pkg::OFF_IN_PORT} ||
    pci_paddr == {24'h000000, msgu_pkg::OFF_OUT_PORT};
  assign pw_port = pci_psel && pci_penable && pci_pwrite && port_addr;
  assign pci_done = pci_psel && pci_penable && pci_pready;
  assign cpu_mask_wr = cpu_psel && cpu_penable && cpu_pready && cpu_pwrite &&
    cpu_paddr == msgu_pkg::CPU_BASE + {24'h000000, msgu_pkg::OFF_IN_MASK};
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  AST_MEM_HOLD: assert property (mem_req && !mem_ack
    |=> mem_req && $stable(mem_we) && $stable(mem_addr) && $stable(mem_wdata))
    else $error("memory request changed before acknowledge");
  AST_DISC: assert property (pci_disconnect |-> pci_done && port_addr)
    else $error("disconnect outside a queue port access");
  AST_RETRY_KIND: assert property (pci_pslverr |-> pw_port)
    else $error("retry outside a queue port write");
  AST_RETRY_PEND: assert property (pw_port && pci_pready && mem_req && mem_we && !mem_ack
    |-> pci_pslverr)
    else $error("port write accepted while a write is pending");
  AST_POSTED: assert property (pw_port && pci_pready && !pci_pslverr
    |=> mem_req && mem_we && mem_wdata == $past(pci_pwdata))
    else $error("accepted port write not sent to memory");
  AST_RD_DATA: assert property (pci_done && !pci_pwrite && $past(mem_ack)
    && $past(!pci_pready) |-> pci_prdata == $past(mem_rdata))
    else $error("read data differs from memory data");
  AST_IN_MASK: assert property (cpu_mask_wr && cpu_pwdata[4:0] == 5'h1F
    |-> ##2 !cpu_int)
    else $error("cpu interrupt while fully masked");
  AST_OUT_MASK: assert property (pci_done && pci_pwrite && pci_pwdata[3:0] == 4'hF &&
    pci_paddr == {24'h000000, msgu_pkg::OFF_OUT_MASK} |-> ##2 !pci_int)
    else $error("pci interrupt while fully masked");
  cover property (pci_pslverr);
  cover property (pci_disconnect);
  cover property ($rose(pci_int));
endmodule

bind msgu_top msgu_chk i_chk (
  .mclk(mclk), .reset(reset), .pci_psel(pci_psel), .pci_penable(pci_penable),
  .pci_pwrite(pci_pwrite), .pci_paddr(pci_paddr), .pci_pwdata(pci_pwdata),
  .pci_pready(pci_pready), .pci_pslverr(pci_pslverr), .pci_prdata(pci_prdata),
  .pci_disconnect(pci_disconnect), .cpu_psel(cpu_psel), .cpu_penable(cpu_penable),
  .cpu_pwrite(cpu_pwrite), .cpu_paddr(cpu_paddr), .cpu_pwdata(cpu_pwdata),
  .cpu_pready(cpu_pready), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
  .cpu_int(cpu_int), .pci_int(pci_int));

// ### tb/msgu_mem_model.sv
`timescale 1ns/10ps
module msgu_mem_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [3:0] cnt = 4'h0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 32'h00000000;
  // Read data toggles outside the acknowledge so stale data never looks valid.
  always @(posedge mclk)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (reset || !mem_req || mem_ack)
    begin
      cnt <= 4'h0;
    end
    else if (cnt < lat)
    begin
      cnt <= cnt + 4'h1;
    end
    else
    begin
      mem_ack <= 1'b1;
      if (mem_we)
      begin
        mem[mem_addr] = mem_wdata;
      end
      else
      begin
        mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h00000000;
      end
    end
  end
endmodule

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  typedef struct {
    bit wc;
    logic [7:0] wo;
    logic [31:0] wd;
    bit rc;
    logic [7:0] ro;
    logic [31:0] ex;
    logic ci;
    logic pi;
  } msgu_row_t;
  localparam logic [31:0] QB = 32'h00100000;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic strap = 1'b1;
  logic [1:0] psel = 2'b00, pen = 2'b00, pwr = 2'b00;
  logic [31:0] padr [2] = '{32'h0, 32'h0};
  logic [31:0] pwd [2] = '{32'h0, 32'h0};
  logic [3:0] lat = 4'h6;
  wire [1:0] rdy, err;
  wire [31:0] prd [2];
  wire mem_req, mem_we, mem_ack, cpu_int, pci_int, disc;
  wire [31:0] mem_addr, mem_wdata, mem_rdata;
  logic [31:0] rd;
  logic er;
  logic dc;
  int n_mismatch = 0;
  int checks = 0;
  msgu_row_t rows [14] = '{
    '{0, 8'h10, 32'hA5A50001, 1, 8'h24, 32'h1, 1, 0},
    '{0, 8'h14, 32'h5A5A0002, 1, 8'h14, 32'h5A5A0002, 1, 0},
    '{1, 8'h24, 32'h0, 1, 8'h24, 32'h3, 1, 0},
    '{1, 8'h24, 32'h3, 1, 8'h24, 32'h0, 0, 0},
    '{0, 8'h20, 32'h3, 1, 8'h20, 32'h3, 1, 0},
    '{1, 8'h20, 32'h1, 1, 8'h20, 32'h2, 1, 0},
    '{1, 8'h20, 32'h2, 1, 8'h20, 32'h0, 0, 0},
    '{1, 8'h18, 32'h0000C0DE, 0, 8'h30, 32'h1, 0, 1},
    '{0, 8'h30, 32'h1, 0, 8'h30, 32'h0, 0, 0},
    '{1, 8'h2C, 32'h4, 0, 8'h2C, 32'h4, 0, 1},
    '{0, 8'h2C, 32'h4, 0, 8'h2C, 32'h0, 0, 0},
    '{1, 8'h1C, 32'h00FACE00, 0, 8'h1C, 32'h00FACE00, 0, 1},
    '{0, 8'h30, 32'h2, 0, 8'h30, 32'h0, 0, 0},
    '{0, 8'h38, 32'hFFFFFFFF, 0, 8'h38, 32'h0, 0, 0}};
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  msgu_top i_dut (
    .mclk(mclk), .reset(reset), .msg_enable_strap(strap),
    .pci_psel(psel[0]), .pci_penable(pen[0]), .pci_pwrite(pwr[0]), .pci_paddr(padr[0]),
    .pci_pwdata(pwd[0]), .pci_pready(rdy[0]), .pci_pslverr(err[0]), .pci_prdata(prd[0]),
    .pci_disconnect(disc), .cpu_psel(psel[1]), .cpu_penable(pen[1]), .cpu_pwrite(pwr[1]),
    .cpu_paddr(padr[1]), .cpu_pwdata(pwd[1]), .cpu_pready(rdy[1]), .cpu_pslverr(err[1]),
    .cpu_prdata(prd[1]), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .cpu_int(cpu_int), .pci_int(pci_int));
  msgu_mem_model i_mem (
    .mclk(mclk), .reset(reset), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic chkw(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: word %h, expected %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: flag %b, expected %b", $time, g, e);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic xfer(input bit c, input bit w, input logic [7:0] off, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel[c] <= 1'b1;
    pwr[c] <= w;
    padr[c] <= (c ? msgu_pkg::CPU_BASE : 32'h0) + {24'h000000, off};
    pwd[c] <= d;
    @(posedge mclk);
    pen[c] <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (rdy[c] !== 1'b1 && n < 300);
    if (n >= 300)
    begin
      n_mismatch++;
      $display("unexpected at %0t: bus wait timed out", $time);
    end
    rd = prd[c];
    er = err[c];
    dc = disc;
    psel[c] <= 1'b0;
    pen[c] <= 1'b0;
  endtask
  task automatic rdc(input bit c, input logic [7:0] off, input logic [31:0] e);
    xfer(c, 1'b0, off, 32'h0);
    chkw(rd, e);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    idle(20000);
    n_mismatch++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop;
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    idle(4);
    reset <= 1'b0;
    idle(6);
    rdc(1, 8'h28, 32'h0);
    rdc(1, 8'h50, 32'h0);
    rdc(0, 8'h34, 32'h0);
    chkb(dc, 1'b0);
    foreach (rows[i])
    begin
      xfer(rows[i].wc, 1'b1, rows[i].wo, rows[i].wd);
      idle(3);
      chkb(cpu_int, rows[i].ci);
      chkb(pci_int, rows[i].pi);
      rdc(rows[i].rc, rows[i].ro, rows[i].ex);
    end
    xfer(1, 1, 8'h28, 32'h1F);
    xfer(0, 1, 8'h10, 32'h1);
    xfer(0, 1, 8'h20, 32'h1);
    idle(3);
    chkb(cpu_int, 1'b0);
    rdc(1, 8'h24, 32'h5);
    xfer(1, 1, 8'h20, 32'h1);
    xfer(1, 1, 8'h24, 32'h1);
    xfer(1, 1, 8'h28, 32'h0);
    xfer(1, 0, 8'h40, 32'h0);
    chkb(er, 1'b1);
    xfer(1, 1, 8'h54, QB);
    xfer(1, 1, 8'h6C, 32'h100);
    rdc(1, 8'h54, QB);
    xfer(0, 1, 8'h40, 32'hD1);
    chkb(er, 1'b0);
    chkb(dc, 1'b1);
    xfer(0, 1, 8'h40, 32'hD2);
    chkb(er, 1'b1);
    idle(12);
    chkw(i_mem.mem[QB + 32'h4000], 32'hD1);
    rdc(1, 8'h68, 32'h4);
    rdc(1, 8'h24, 32'h8);
    chkb(cpu_int, 1'b1);
    xfer(1, 1, 8'h24, 32'h8);
    xfer(1, 1, 8'h68, 32'h3FFC);
    xfer(0, 1, 8'h40, 32'hD3);
    idle(12);
    chkw(i_mem.mem[QB + 32'h7FFC], 32'hD3);
    rdc(1, 8'h68, 32'h0);
    xfer(1, 1, 8'h6C, 32'h4);
    xfer(0, 1, 8'h40, 32'hD4);
    chkb(er, 1'b1);
    idle(12);
    rdc(1, 8'h68, 32'h0);
    xfer(1, 1, 8'h24, 32'h8);
    lat <= 4'h0;
    i_mem.mem[QB + 32'h4] = 32'hE1;
    xfer(1, 1, 8'h60, 32'h8);
    xfer(1, 1, 8'h64, 32'h4);
    rdc(0, 8'h40, 32'hE1);
    chkb(dc, 1'b1);
    rdc(1, 8'h64, 32'h8);
    rdc(0, 8'h40, 32'hFFFFFFFF);
    rdc(1, 8'h64, 32'h8);
    lat <= 4'h6;
    i_mem.mem[QB + 32'h8000] = 32'hE2;
    xfer(1, 1, 8'h78, 32'h4);
    idle(3);
    chkb(pci_int, 1'b1);
    xfer(0, 1, 8'h34, 32'hF);
    idle(3);
    chkb(pci_int, 1'b0);
    xfer(0, 1, 8'h34, 32'h0);
    rdc(0, 8'h44, 32'hE2);
    rdc(1, 8'h7C, 32'h4);
    idle(3);
    chkb(pci_int, 1'b0);
    xfer(1, 1, 8'h50, 32'h4);
    xfer(1, 1, 8'h74, 32'h8);
    xfer(0, 1, 8'h44, 32'hE3);
    chkb(er, 1'b0);
    idle(12);
    chkw(i_mem.mem[QB + 32'hC0000], 32'hE3);
    rdc(1, 8'h70, 32'h4);
    rdc(1, 8'h24, 32'h10);
    i_mem.mem[32'h0] = 32'hE4;
    rdc(0, 8'h00, 32'hE4);
    strap <= 1'b0;
    reset <= 1'b1;
    idle(4);
    reset <= 1'b0;
    idle(6);
    i_mem.mem[32'h10] = 32'hE5;
    rdc(0, 8'h10, 32'hE5);
    report_and_stop;
  end
endmodule
